// ===== src/csf_pkg.sv
// Package for the channel status and interrupt flag block
// Operation
// - Empty flags bits 0 and 4 high when FIFO holds nothing; idle reads 0x13
// - Full flags bits 2 and 6 high while no free location remains
// - Receive FIFO flags use FIFO storage only, not the four-stage pipeline
// - Receive almost-full bit 5 set when FIFO count exceeds fill threshold
// - Transmit almost-empty bit 1 set when count at or below drain threshold
// - Live transmit level bit 8 set while transmit count below drain threshold
// - Live receive level bit 9 set while FIFO plus pipeline above fill threshold
// - Sticky bit 10 set on transmit count falling below threshold; write one clears
// - Sticky bit 11 set on receive count rising above threshold; write one clears
// - DMA error bits 12 and 13 latch on aborts or bad direction; write one clears
// - DMA interrupt bits 14 and 15 latch on list completion until serviced
// - Sticky transmit-complete bit 16 set on programmed length reached
// - LVDS and RS485 channels: bit 17 latches receive end: valid strobe drop or frame signal
// - Manchester channel: bit 17 flags decode error after lock
// - UART channel: bit 17 sticky stop level error; write one clears
// - UART with parity: bit 19 sticky parity mismatch; write one clears
// - Sticky receive overflow bit 18 when storing into full FIFO
// - Non-UART: sticky transmit underflow bit 19 when reading empty FIFO
// - Bits 20 and 21 report receive and transmit idle states
// - Bits 22 and 23 report burst-out and burst-in DMA idle
// - Bit 30 is masked OR of non-DMA sources and control force bit 4, before master enable
// - Bit 31 combines local and DMA interrupts gated by master enable
// - Channel interrupt enable passes non-DMA sources only when set
package csf_pkg;
   localparam logic [7:0] CSF_STATUS_ADDR = 8'h04;
   localparam logic [7:0] CSF_CTRL_ADDR = 8'h00;
   localparam logic [7:0] CSF_TXLVL_ADDR = 8'h14;
   localparam logic [7:0] CSF_RXLVL_ADDR = 8'h18;
   localparam logic [7:0] CSF_SRCEN_ADDR = 8'h1C;
   localparam int B_TX_EMPTY = 0;
   localparam int B_TX_AE = 1;
   localparam int B_TX_FULL = 2;
   localparam int B_RX_EMPTY = 4;
   localparam int B_RX_AF = 5;
   localparam int B_RX_FULL = 6;
   localparam int B_TX_LVL = 8;
   localparam int B_RX_LVL = 9;
   localparam int B_TX_LAT = 10;
   localparam int B_RX_LAT = 11;
   localparam int B_WDMA_ERR = 12;
   localparam int B_RDMA_ERR = 13;
   localparam int B_WDMA_INT = 14;
   localparam int B_RDMA_INT = 15;
   localparam int B_TX_DONE = 16;
   localparam int B_RX_DONE = 17;
   localparam int B_RX_OVF = 18;
   localparam int B_TX_UNF = 19;
   localparam int B_RX_IDLE = 20;
   localparam int B_TX_IDLE = 21;
   localparam int B_BO_IDLE = 22;
   localparam int B_BI_IDLE = 23;
   localparam int B_LOCAL = 30;
   localparam int B_INT = 31;
   localparam int C_FORCE = 4;
   localparam int C_CHAN_IE = 3;
   localparam int C_WDMA_IE = 5;
   localparam int C_RDMA_IE = 6;
   localparam int C_MASTER_IE = 7;
   localparam logic [31:0] CSF_CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] CSF_LVL_RESET = 16'h0000;
   localparam logic [31:0] CSF_SRCEN_RESET = 32'h0000_0000;
   localparam logic [31:0] CSF_STICKY_MASK = 32'h000F_FC00;
   localparam logic [31:0] CSF_NONDMA_SRC = 32'h000F_0F00;
   localparam int CSF_PIPE_DEPTH = 4;
   typedef enum {CSF_LVDS, CSF_RS485, CSF_UART, CSF_MANCH} csf_chan_t;
   typedef struct packed {
      logic rx_end;
      logic biphase_decode_error;
      logic uart_stop_level_error;
      logic uart_parity_mismatch;
      logic tx_done;
      logic rx_store_full;
      logic tx_read_empty;
      logic rx_idle;
      logic tx_idle;
   } csf_engine_t;
   typedef struct packed {
      logic wr_err;
      logic rd_err;
      logic wr_done;
      logic rd_done;
      logic burst_in_idle;
      logic burst_out_idle;
   } csf_dma_t;
endpackage

// ===== src/csf_status.sv
// Channel status register with sticky flags and interrupt combine
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module csf_status import csf_pkg::*; #(
   parameter int CNT_W = 16,
   parameter csf_chan_t CHAN = CSF_LVDS,
   parameter logic PARITY_EN = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // FIFO state
   input wire logic [CNT_W-1:0] tx_count,
   input wire logic tx_full,
   input wire logic [CNT_W-1:0] rx_fifo_count,
   input wire logic [2:0] rx_pipe_count,
   input wire logic rx_full,
   // Engine and DMA events
   input wire csf_engine_t eng,
   input wire csf_dma_t dma,
   // Interrupt out
   output logic chan_irq
);
   if (CNT_W < 4 || CNT_W > 16) begin : g_bad_cnt_w
      $error("CNT_W out of range");
   end

   logic [31:0] ctrl;
   logic [15:0] transmit_drain_threshold;
   logic [15:0] receive_fill_threshold;
   logic [31:0] src_en;
   logic [31:0] sticky;
   logic tx_lvl_d;
   logic rx_lvl_d;
   logic [31:0] status;
   logic [CNT_W:0] rx_comb;
   logic tx_drain_live_level;
   logic rx_fill_live_level;
   logic local_int;
   logic [31:0] set_ev;
   logic [31:0] clr;

   assign rx_comb = {1'b0, rx_fifo_count} + {{(CNT_W-2){1'b0}}, rx_pipe_count};
   assign tx_drain_live_level = {16'h0000, tx_count} < {16'h0000, transmit_drain_threshold};
   assign rx_fill_live_level = {15'h0000, rx_comb} > {16'h0000, receive_fill_threshold};

   // Control, levels and source enables
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= CSF_CTRL_RESET;
         transmit_drain_threshold <= CSF_LVL_RESET;
         receive_fill_threshold <= CSF_LVL_RESET;
         src_en <= CSF_SRCEN_RESET;
      end else if (wr) begin
         if (addr == CSF_CTRL_ADDR) begin
            ctrl <= wdata;
         end
         if (addr == CSF_TXLVL_ADDR) begin
            transmit_drain_threshold <= wdata[15:0];
         end
         if (addr == CSF_RXLVL_ADDR) begin
            receive_fill_threshold <= wdata[15:0];
         end
         if (addr == CSF_SRCEN_ADDR) begin
            src_en <= wdata;
         end
      end
   end

   // Level history for crossing detect
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_lvl_d <= 1'b0;
         rx_lvl_d <= 1'b0;
      end else begin
         tx_lvl_d <= tx_drain_live_level;
         rx_lvl_d <= rx_fill_live_level;
      end
   end

   // Event sources
   always_comb begin
      set_ev = 32'h0000_0000;
      set_ev[B_TX_LAT] = tx_drain_live_level && !tx_lvl_d;
      set_ev[B_RX_LAT] = rx_fill_live_level && !rx_lvl_d;
      set_ev[B_WDMA_ERR] = dma.wr_err;
      set_ev[B_RDMA_ERR] = dma.rd_err;
      set_ev[B_WDMA_INT] = dma.wr_done;
      set_ev[B_RDMA_INT] = dma.rd_done;
      set_ev[B_TX_DONE] = eng.tx_done;
      unique case (CHAN)
         CSF_UART: begin
            set_ev[B_RX_DONE] = eng.uart_stop_level_error;
            set_ev[B_TX_UNF] = PARITY_EN && eng.uart_parity_mismatch;
         end
         CSF_MANCH: begin
            set_ev[B_RX_DONE] = eng.biphase_decode_error;
            set_ev[B_TX_UNF] = eng.tx_read_empty;
         end
         CSF_LVDS, CSF_RS485: begin
            set_ev[B_RX_DONE] = eng.rx_end;
            set_ev[B_TX_UNF] = eng.tx_read_empty;
         end
      endcase
      set_ev[B_RX_OVF] = eng.rx_store_full;
   end

   assign clr = (wr && addr == CSF_STATUS_ADDR) ? (wdata & CSF_STICKY_MASK) : 32'h0000_0000;

   // Sticky latches, set wins over clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sticky <= 32'h0000_0000;
      end else begin
         sticky <= ((sticky & ~clr) | set_ev) & CSF_STICKY_MASK;
      end
   end

   // Local and channel interrupt
   always_comb begin
      local_int = (|(status & src_en & CSF_NONDMA_SRC)) || ctrl[C_FORCE];
   end

   always_comb begin
      status = sticky;
      status[B_TX_EMPTY] = (tx_count == '0);
      status[B_TX_AE] = {16'h0000, tx_count} <= {16'h0000, transmit_drain_threshold};
      status[B_TX_FULL] = tx_full;
      status[B_RX_EMPTY] = (rx_fifo_count == '0);
      status[B_RX_AF] = {16'h0000, rx_fifo_count} > {16'h0000, receive_fill_threshold};
      status[B_RX_FULL] = rx_full;
      status[B_TX_LVL] = tx_drain_live_level;
      status[B_RX_LVL] = rx_fill_live_level;
      status[B_RX_IDLE] = eng.rx_idle;
      status[B_TX_IDLE] = eng.tx_idle;
      status[B_BO_IDLE] = dma.burst_out_idle;
      status[B_BI_IDLE] = dma.burst_in_idle;
   end

   logic chan_int;
   assign chan_int = ctrl[C_MASTER_IE] && ((ctrl[C_CHAN_IE] && local_int)
      || (ctrl[C_WDMA_IE] && sticky[B_WDMA_INT]) || (ctrl[C_RDMA_IE] && sticky[B_RDMA_INT]));

   // Read data, one cycle after strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         unique case (addr)
            CSF_STATUS_ADDR: rdata <= {chan_int, local_int, status[29:0]};
            CSF_CTRL_ADDR: rdata <= ctrl;
            CSF_TXLVL_ADDR: rdata <= {16'h0000, transmit_drain_threshold};
            CSF_RXLVL_ADDR: rdata <= {16'h0000, receive_fill_threshold};
            CSF_SRCEN_ADDR: rdata <= src_en;
            default: rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chan_irq <= 1'b0;
      end else begin
         chan_irq <= chan_int;
      end
   end

   // Checks
   property p_tx_empty;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR && tx_count == '0 |=> rdata[B_TX_EMPTY];
   endproperty
   a_tx_empty: assert property (p_tx_empty) else $error("tx empty wrong");
   property p_full;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR |=> rdata[B_RX_FULL] == $past(rx_full);
   endproperty
   a_full: assert property (p_full) else $error("rx full wrong");
   property p_txlat;
      @(posedge clk) disable iff (!nrst) !tx_lvl_d && tx_drain_live_level |=> sticky[B_TX_LAT];
   endproperty
   a_txlat: assert property (p_txlat) else $error("tx latch missed");
   property p_rxlat_hold;
      @(posedge clk) disable iff (!nrst) sticky[B_RX_LAT] && !clr[B_RX_LAT] |=> sticky[B_RX_LAT];
   endproperty
   a_rxlat_hold: assert property (p_rxlat_hold) else $error("rx latch dropped");
   property p_ovf;
      @(posedge clk) disable iff (!nrst) eng.rx_store_full |=> sticky[B_RX_OVF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow missed");
   property p_derr;
      @(posedge clk) disable iff (!nrst) dma.wr_err ##1 !clr[B_WDMA_ERR] |=> sticky[B_WDMA_ERR];
   endproperty
   a_derr: assert property (p_derr) else $error("dma error lost");
   property p_irq;
      @(posedge clk) disable iff (!nrst) !ctrl[C_MASTER_IE] |=> !chan_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq without master enable");
   property p_done;
      @(posedge clk) disable iff (!nrst) eng.tx_done |=> sticky[B_TX_DONE];
   endproperty
   a_done: assert property (p_done) else $error("tx done missed");

   property p_rx_empty;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR |=> rdata[B_RX_EMPTY] == $past(rx_fifo_count == '0);
   endproperty
   a_rx_empty: assert property (p_rx_empty) else $error("rx empty wrong");

   property p_tx_full;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR |=> rdata[B_TX_FULL] == $past(tx_full);
   endproperty
   a_tx_full: assert property (p_tx_full) else $error("tx full wrong");

   property p_rx_af;
      @(posedge clk) disable iff (!nrst)
         rd && addr == CSF_STATUS_ADDR |=> rdata[B_RX_AF] == $past(rx_fifo_count > receive_fill_threshold);
   endproperty
   a_rx_af: assert property (p_rx_af) else $error("rx almost full wrong");

   property p_tx_ae;
      @(posedge clk) disable iff (!nrst)
         rd && addr == CSF_STATUS_ADDR |=> rdata[B_TX_AE] == $past(tx_count <= transmit_drain_threshold);
   endproperty
   a_tx_ae: assert property (p_tx_ae) else $error("tx almost empty wrong");

   property p_tx_lvl;
      @(posedge clk) disable iff (!nrst)
         rd && addr == CSF_STATUS_ADDR |=> rdata[B_TX_LVL] == $past(tx_count < transmit_drain_threshold);
   endproperty
   a_tx_lvl: assert property (p_tx_lvl) else $error("tx live level wrong");

   property p_rx_lvl;
      @(posedge clk) disable iff (!nrst)
         rd && addr == CSF_STATUS_ADDR |=> rdata[B_RX_LVL] == $past(rx_comb > receive_fill_threshold);
   endproperty
   a_rx_lvl: assert property (p_rx_lvl) else $error("rx live level wrong");

   property p_rxlat;
      @(posedge clk) disable iff (!nrst) !rx_lvl_d && rx_fill_live_level |=> sticky[B_RX_LAT];
   endproperty
   a_rxlat: assert property (p_rxlat) else $error("rx latch missed");

   property p_txlat_hold;
      @(posedge clk) disable iff (!nrst) sticky[B_TX_LAT] && !clr[B_TX_LAT] |=> sticky[B_TX_LAT];
   endproperty
   a_txlat_hold: assert property (p_txlat_hold) else $error("tx latch dropped");

   property p_txlat_clear;
      @(posedge clk) disable iff (!nrst) clr[B_TX_LAT] && !set_ev[B_TX_LAT] |=> !sticky[B_TX_LAT];
   endproperty
   a_txlat_clear: assert property (p_txlat_clear) else $error("tx latch not cleared");

   property p_rderr;
      @(posedge clk) disable iff (!nrst) dma.rd_err |=> sticky[B_RDMA_ERR];
   endproperty
   a_rderr: assert property (p_rderr) else $error("read dma error missed");

   property p_wdone;
      @(posedge clk) disable iff (!nrst) dma.wr_done |=> sticky[B_WDMA_INT];
   endproperty
   a_wdone: assert property (p_wdone) else $error("write dma done missed");

   property p_rdone;
      @(posedge clk) disable iff (!nrst) dma.rd_done |=> sticky[B_RDMA_INT];
   endproperty
   a_rdone: assert property (p_rdone) else $error("read dma done missed");

   property p_rx_end;
      @(posedge clk) disable iff (!nrst) (CHAN == CSF_LVDS || CHAN == CSF_RS485) && eng.rx_end |=> sticky[B_RX_DONE];
   endproperty
   a_rx_end: assert property (p_rx_end) else $error("rx complete missed");

   property p_biphase;
      @(posedge clk) disable iff (!nrst) CHAN == CSF_MANCH && eng.biphase_decode_error |=> sticky[B_RX_DONE];
   endproperty
   a_biphase: assert property (p_biphase) else $error("decode error missed");

   property p_stop;
      @(posedge clk) disable iff (!nrst) CHAN == CSF_UART && eng.uart_stop_level_error |=> sticky[B_RX_DONE];
   endproperty
   a_stop: assert property (p_stop) else $error("stop level error missed");

   property p_parity;
      @(posedge clk) disable iff (!nrst) CHAN == CSF_UART && PARITY_EN && eng.uart_parity_mismatch |=> sticky[B_TX_UNF];
   endproperty
   a_parity: assert property (p_parity) else $error("parity error missed");

   property p_unf;
      @(posedge clk) disable iff (!nrst) CHAN != CSF_UART && eng.tx_read_empty |=> sticky[B_TX_UNF];
   endproperty
   a_unf: assert property (p_unf) else $error("underflow missed");

   property p_rx_idle;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR |=> rdata[B_RX_IDLE] == $past(eng.rx_idle);
   endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("rx idle wrong");

   property p_tx_idle;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR |=> rdata[B_TX_IDLE] == $past(eng.tx_idle);
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("tx idle wrong");

   property p_bo_idle;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR |=> rdata[B_BO_IDLE] == $past(dma.burst_out_idle);
   endproperty
   a_bo_idle: assert property (p_bo_idle) else $error("burst out idle wrong");

   property p_bi_idle;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR |=> rdata[B_BI_IDLE] == $past(dma.burst_in_idle);
   endproperty
   a_bi_idle: assert property (p_bi_idle) else $error("burst in idle wrong");

   property p_local_off;
      @(posedge clk) disable iff (!nrst)
         rd && addr == CSF_STATUS_ADDR && !ctrl[C_FORCE] && src_en == 32'h0000_0000 |=> !rdata[B_LOCAL];
   endproperty
   a_local_off: assert property (p_local_off) else $error("local int without source");

   property p_force;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR && ctrl[C_FORCE] |=> rdata[B_LOCAL];
   endproperty
   a_force: assert property (p_force) else $error("forced local int missing");

   property p_chan_ie;
      @(posedge clk) disable iff (!nrst) !ctrl[C_CHAN_IE] && !ctrl[C_WDMA_IE] && !ctrl[C_RDMA_IE] |=> !chan_irq;
   endproperty
   a_chan_ie: assert property (p_chan_ie) else $error("irq without any enable");

   property p_dma_irq;
      @(posedge clk) disable iff (!nrst) ctrl[C_MASTER_IE] && ctrl[C_WDMA_IE] && sticky[B_WDMA_INT] |=> chan_irq;
   endproperty
   a_dma_irq: assert property (p_dma_irq) else $error("dma irq missing");

   property p_rd_idle;
      @(posedge clk) disable iff (!nrst) !rd |=> rdata == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

   property p_spare;
      @(posedge clk) disable iff (!nrst) rd && addr == CSF_STATUS_ADDR |=> rdata[29:24] == 6'h00 && !rdata[7] && !rdata[3];
   endproperty
   a_spare: assert property (p_spare) else $error("spare status bit set");
   c_irq: cover property (@(posedge clk) disable iff (!nrst) chan_irq);
   c_clear: cover property (@(posedge clk) disable iff (!nrst) sticky[B_TX_LAT] ##1 !sticky[B_TX_LAT]);
   c_rxlat: cover property (@(posedge clk) disable iff (!nrst) set_ev[B_RX_LAT]);
   c_force: cover property (@(posedge clk) disable iff (!nrst) ctrl[C_FORCE] && chan_irq);
   c_ovf: cover property (@(posedge clk) disable iff (!nrst) sticky[B_RX_OVF]);
endmodule

// ===== tb/csf_status_test.sv
// Self-checking testbench for the channel status flag block
`timescale 1ns/1ps
module csf_status_test import csf_pkg::*;;
   logic clk, nrst, wr, rd, tx_full, rx_full, chan_irq;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [31:0] rdata_u, rdata_m, d_u, d_m;
   logic chan_irq_u, chan_irq_m;
   logic [15:0] tx_count, rx_fifo_count;
   logic [2:0] rx_pipe_count;
   logic [14:0] ev;
   int fails, n_checks;
   csf_status DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .tx_count(tx_count), .tx_full(tx_full), .rx_fifo_count(rx_fifo_count), .rx_pipe_count(rx_pipe_count),
      .rx_full(rx_full), .eng(csf_engine_t'(ev[14:6])), .dma(csf_dma_t'(ev[5:0])), .chan_irq(chan_irq));
   csf_status #(.CHAN(CSF_UART), .PARITY_EN(1'b1)) DUT_UART (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata_u), .tx_count(tx_count), .tx_full(tx_full), .rx_fifo_count(rx_fifo_count),
      .rx_pipe_count(rx_pipe_count), .rx_full(rx_full), .eng(csf_engine_t'(ev[14:6])), .dma(csf_dma_t'(ev[5:0])),
      .chan_irq(chan_irq_u));
   csf_status #(.CHAN(CSF_MANCH)) DUT_MANCH (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata_m), .tx_count(tx_count), .tx_full(tx_full), .rx_fifo_count(rx_fifo_count),
      .rx_pipe_count(rx_pipe_count), .rx_full(rx_full), .eng(csf_engine_t'(ev[14:6])), .dma(csf_dma_t'(ev[5:0])),
      .chan_irq(chan_irq_m));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      d_u = rdata_u;
      d_m = rdata_m;
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      ev <= ev | (15'h0001 << i);
      @(posedge clk);
      ev <= ev & ~(15'h0001 << i);
   endtask
   task automatic lvl(input logic [15:0] tc, input logic [15:0] rc, input logic [2:0] pc, input logic tf,
      input logic rf, input logic [9:0] exp);
      @(posedge clk);
      tx_count <= tc;
      rx_fifo_count <= rc;
      rx_pipe_count <= pc;
      tx_full <= tf;
      rx_full <= rf;
      rreg(CSF_STATUS_ADDR);
      chk({22'h0, d[9:0]}, {22'h0, exp});
   endtask
   task automatic t_reset;
      rreg(CSF_STATUS_ADDR);
      chk(d, 32'h0000_0013);
      rreg(CSF_TXLVL_ADDR);
      chk(d, {16'h0, CSF_LVL_RESET});
      rreg(CSF_SRCEN_ADDR);
      chk(d, CSF_SRCEN_RESET);
      wreg(8'h40, 32'hFFFF_FFFF);
      rreg(8'h40);
      chk(d, 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_idle;
      logic [14:0] v [4] = '{15'h0080, 15'h0040, 15'h0001, 15'h0002};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         ev <= v[i];
         rreg(CSF_STATUS_ADDR);
         chk({28'h0, d[23:20]}, 32'h1 << i);
      end
      @(posedge clk);
      ev <= 15'h0000;
      $display("test idle done");
   endtask
   task automatic t_levels;
      wreg(CSF_TXLVL_ADDR, 32'h0000_0005);
      wreg(CSF_RXLVL_ADDR, 32'h0000_0005);
      lvl(16'h0000, 16'h0000, 3'h4, 1'b0, 1'b0, 10'h113);
      lvl(16'h0004, 16'h0005, 3'h1, 1'b0, 1'b0, 10'h302);
      lvl(16'h0005, 16'h0006, 3'h0, 1'b0, 1'b1, 10'h262);
      lvl(16'h0006, 16'h0005, 3'h0, 1'b1, 1'b0, 10'h004);
      $display("test levels done");
   endtask
   task automatic t_cross;
      wreg(CSF_STATUS_ADDR, CSF_STICKY_MASK);
      rreg(CSF_STATUS_ADDR);
      chk({30'h0, d[11:10]}, 32'h0);
      lvl(16'h0004, 16'h0006, 3'h0, 1'b0, 1'b0, 10'h322);
      lvl(16'h0006, 16'h0005, 3'h0, 1'b0, 1'b0, 10'h000);
      chk({30'h0, d[11:10]}, 32'h3);
      wreg(CSF_STATUS_ADDR, 32'h0000_0400);
      rreg(CSF_STATUS_ADDR);
      chk({30'h0, d[11:10]}, 32'h2);
      wreg(CSF_STATUS_ADDR, 32'h0000_0800);
      rreg(CSF_STATUS_ADDR);
      chk({30'h0, d[11:10]}, 32'h0);
      $display("test crossing done");
   endtask
   task automatic t_sticky;
      int idx [8] = '{5, 4, 3, 2, 10, 14, 9, 8};
      for (int i = 0; i < 8; i++) begin
         pulse(idx[i]);
         wreg(CSF_STATUS_ADDR, 32'h0000_0000);
         rreg(CSF_STATUS_ADDR);
         chk({24'h0, d[19:12]}, 32'h1 << i);
         wreg(CSF_STATUS_ADDR, 32'h1000 << i);
         rreg(CSF_STATUS_ADDR);
         chk({24'h0, d[19:12]}, 32'h0);
      end
      $display("test sticky done");
   endtask
   task automatic t_modes;
      int idx [4] = '{12, 11, 13, 8};
      logic [5:0] e [4] = '{6'h04, 6'h08, 6'h01, 6'h22};
      for (int i = 0; i < 4; i++) begin
         pulse(idx[i]);
         rreg(CSF_STATUS_ADDR);
         chk({26'h0, d[19], d[17], d_u[19], d_u[17], d_m[19], d_m[17]}, {26'h0, e[i]});
         wreg(CSF_STATUS_ADDR, 32'h000A_0000);
      end
      $display("test modes done");
   endtask
   task automatic t_irq;
      wreg(CSF_CTRL_ADDR, 32'h0000_0088);
      pulse(10);
      rreg(CSF_STATUS_ADDR);
      chk({30'h0, d[31:30]}, 32'h0);
      wreg(CSF_SRCEN_ADDR, 32'h0001_0000);
      rreg(CSF_STATUS_ADDR);
      chk({30'h0, d[31:30]}, 32'h3);
      chk({31'h0, chan_irq}, 32'h1);
      wreg(CSF_CTRL_ADDR, 32'h0000_0008);
      rreg(CSF_STATUS_ADDR);
      chk({30'h0, d[31:30]}, 32'h1);
      wreg(CSF_CTRL_ADDR, 32'h0000_0080);
      rreg(CSF_STATUS_ADDR);
      chk({31'h0, d[31]}, 32'h0);
      wreg(CSF_STATUS_ADDR, 32'h0001_0000);
      wreg(CSF_CTRL_ADDR, 32'h0000_00A0);
      pulse(3);
      rreg(CSF_STATUS_ADDR);
      chk({30'h0, d[31:30]}, 32'h2);
      wreg(CSF_STATUS_ADDR, 32'h0000_4000);
      rreg(CSF_STATUS_ADDR);
      chk({31'h0, d[31]}, 32'h0);
      wreg(CSF_CTRL_ADDR, 32'h0000_0098);
      rreg(CSF_STATUS_ADDR);
      chk({30'h0, d[31:30]}, 32'h3);
      $display("test interrupt done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      fails++;
      finish_test();
   end
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      tx_count = 16'h0;
      rx_fifo_count = 16'h0;
      rx_pipe_count = 3'h0;
      tx_full = 1'b0;
      rx_full = 1'b0;
      ev = 15'h0;
      fails = 0;
      n_checks = 0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_idle();
      t_levels();
      t_cross();
      t_sticky();
      t_modes();
      t_irq();
      finish_test();
   end
endmodule
